// File: common/scr_pkg.sv
package scr_pkg;

  // ----------------------------------------------------------------
  // register counts and offsets
  // ----------------------------------------------------------------
  localparam int         SCR_SER_REGS       = 15;
  localparam int         SCR_DES_REGS       = 8;
  localparam logic [7:0] SCR_OFS_FORMAT     = 8'h00;
  localparam logic [7:0] SCR_OFS_SPREAD     = 8'h01;
  localparam logic [7:0] SCR_OFS_START_TO   = 8'h02;
  localparam logic [7:0] SCR_OFS_END_TO     = 8'h03;
  localparam logic [7:0] SCR_OFS_EDGE       = 8'h04;
  localparam logic [7:0] SCR_OFS_OWN_ADDR   = 8'h05;
  localparam logic [7:0] SCR_OFS_END_FRAME  = 8'h06;
  localparam logic [7:0] SCR_OFS_REMOTE     = 8'h07;
  localparam logic [7:0] SCR_OFS_DES_PERIPH = 8'h07;
  localparam logic [7:0] SCR_OFS_PERIPH     = 8'h08;
  localparam logic [7:0] SCR_OFS_TEST_PINS  = 8'h09;
  localparam logic [7:0] SCR_OFS_DIR_LOW    = 8'h0A;
  localparam logic [7:0] SCR_OFS_VAL_LOW    = 8'h0B;
  localparam logic [7:0] SCR_OFS_EMPHASIS   = 8'h0C;
  localparam logic [7:0] SCR_OFS_FILTER     = 8'h0D;
  localparam logic [7:0] SCR_OFS_LOCK       = 8'h0E;
  localparam logic [7:0] SCR_OFS_ERR_FIRST  = 8'h0A;
  localparam logic [7:0] SCR_OFS_ERR_LAST   = 8'h0D;

  // ----------------------------------------------------------------
  // power-up values, index 0 rightmost
  // ----------------------------------------------------------------
  localparam logic [14:0][7:0] SCR_SER_RESET = {
    8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF8,
    8'hFF, 8'hFA, 8'h28, 8'hA0, 8'hA0, 8'h1F, 8'hB5};
  localparam logic [7:0][7:0]  SCR_DES_RESET = {
    8'h00, 8'hFF, 8'hF8, 8'h20, 8'hA0, 8'hA0, 8'h00, 8'hB5};
  localparam logic [7:0]       SCR_EDGE_STRAP_LO = 8'h28;
  localparam logic [7:0]       SCR_EDGE_STRAP_HI = 8'h30;

  // writable bits; reserved and read-only bits are zero here
  localparam logic [14:0][7:0] SCR_SER_WMASK = {
    8'h00, 8'h03, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hBD, 8'hFF, 8'hFF, 8'hE0, 8'hFF};
  localparam logic [7:0][7:0]  SCR_DES_WMASK = {
    8'hFF, 8'hFF, 8'hFF, 8'hE1, 8'hFF, 8'hFF, 8'hE0, 8'hFF};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCR_DIV_LSB        = 4;
  localparam int SCR_AUTO_ERR_BIT   = 5;
  localparam int SCR_LOCK_BIT       = 0;
  localparam int SCR_POWER_DOWN_BIT = 4;
  localparam int SCR_SER_ON_BIT     = 3;
  localparam int SCR_HI_DIR_LSB     = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SCR_INIT_WAIT = 2'h2;
  localparam int         SCR_TIMERS    = 4;

endpackage

// File: src/scr_config_bank.sv
`timescale 1ns/1ps

// How it works
// (RULE_01) both link format registers power up to 0xB5
// (RULE_02) serializer spread register powers up to 0x1F, spread off
// (RULE_03) deserializer offset one powers up to 0x00, spread off
// (RULE_04) with auto error reset clear, reading error registers clears counts
// (RULE_05) start timer ticks at clock over 2^divider code, expires after count+1
// (RULE_06) end timer likewise with own codes; both timeout registers reset 0xA0
// (RULE_07) remote strap low gives edge register 0x28, high gives 0x30
// (RULE_08) serializer defaults: falling vsync, rising clock, pll kept, test off
// (RULE_09) deserializer edge register powers up to 0x20
// (RULE_10) own addresses 0xFA and 0xF8; serializer keeps remote address at seven
// (RULE_11) both end-of-frame bytes at offset six power up to 0xFF
// (RULE_12) peripheral register resets 0x00: uart selected, port off
// (RULE_13) fast bit 0 and base rate code 00 by default
// (RULE_14) come-back timeout code defaults to 000, never return
// (RULE_15) pattern length field defaults to 0000
// (RULE_16) ten pin direction bits and value bits default to 0
// (RULE_17) emphasis register powers up to 0xE0, low five bits stay zero
// (RULE_18) glitch filter field defaults to 00
// (RULE_19) control unit programs registers only during the control channel
// (RULE_20) every register loads its reset value; reserved bits ignore writes
module scr_config_bank
  import scr_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                ce_in,
  input  wire logic                remote_strap_in,
  input  wire logic                ser_locked_in,
  input  wire logic                cc_bank_in,
  input  wire logic                cc_wr_in,
  input  wire logic                cc_rd_in,
  input  wire logic [7:0]          cc_addr_in,
  input  wire logic [7:0]          cc_wdata_in,
  input  wire logic [3:0][7:0]     des_err_data_in,
  input  wire logic [3:0]          timer_restart_in,
  output logic [7:0]               cc_rdata_out,
  output logic                     cc_rvalid_out,
  output logic                     init_done_out,
  output logic [14:0][7:0]         ser_cfg_out,
  output logic [7:0][7:0]          des_cfg_out,
  output logic [9:0]               ser_pin_dir_out,
  output logic [9:0]               ser_pin_value_out,
  output logic [3:0]               des_err_clear_out,
  output logic [3:0]               timer_expired_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [14:0][7:0] ser;
    logic [7:0][7:0]  des;
    logic [7:0]       rdata;
    logic             rvalid;
    logic [1:0]       init_cnt;
    logic             init_done;
    logic             strap_meta;
    logic             strap_sync;
    logic             lock_meta;
    logic             lock_sync;
    logic [3:0]       err_clr;
    logic [3:0][15:0] pre;
    logic [3:0][3:0]  cnt;
    logic [3:0]       armed;
    logic [3:0]       expired;
  } scr_state_s;

  scr_state_s s;
  scr_state_s next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  idx;
    logic [3:0]  div;
    logic [3:0]  term;
    logic [7:0]  cfg;
    logic [15:0] limit;
    idx   = cc_addr_in[3:0];
    div   = 4'h0;
    term  = 4'h0;
    cfg   = 8'h00;
    limit = 16'h0000;
    next_s = s;
    next_s.rvalid  = 1'b0;
    next_s.err_clr = 4'h0;
    next_s.expired = 4'h0;

    // pins come from outside the clock domain
    next_s.strap_meta = remote_strap_in;
    next_s.strap_sync = s.strap_meta;
    next_s.lock_meta  = ser_locked_in;
    next_s.lock_sync  = s.lock_meta;
    next_s.ser[SCR_OFS_LOCK[3:0]] = 8'h00;
    next_s.ser[SCR_OFS_LOCK[3:0]][SCR_LOCK_BIT] = s.lock_sync;

    // strap caught once the synchroniser has filled
    // (RULE_07) strap sets edge register
    if (!s.init_done) begin
      if (s.init_cnt == SCR_INIT_WAIT) begin
        next_s.init_done = 1'b1;
        next_s.ser[SCR_OFS_EDGE[3:0]] =
          s.strap_sync ? SCR_EDGE_STRAP_HI : SCR_EDGE_STRAP_LO;
      end else begin
        next_s.init_cnt = s.init_cnt + 2'h1;
      end
    end

    // writes wait for the strap load so it cannot be overwritten
    // (RULE_20) reserved bits hold
    if (cc_wr_in && s.init_done) begin
      if (!cc_bank_in && cc_addr_in < 8'(SCR_SER_REGS)) begin
        next_s.ser[idx] = (s.ser[idx] & ~SCR_SER_WMASK[idx])
                        | (cc_wdata_in & SCR_SER_WMASK[idx]);
      end else if (cc_bank_in && cc_addr_in < 8'(SCR_DES_REGS)) begin
        next_s.des[idx[2:0]] = (s.des[idx[2:0]] & ~SCR_DES_WMASK[idx[2:0]])
                             | (cc_wdata_in & SCR_DES_WMASK[idx[2:0]]);
      end
    end

    // read data one cycle later; unmapped reads return zero
    if (cc_rd_in) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = 8'h00;
      if (!cc_bank_in && cc_addr_in < 8'(SCR_SER_REGS)) begin
        next_s.rdata = s.ser[idx];
      end else if (cc_bank_in && cc_addr_in < 8'(SCR_DES_REGS)) begin
        next_s.rdata = s.des[idx[2:0]];
      end else if (cc_bank_in && cc_addr_in >= SCR_OFS_ERR_FIRST
                   && cc_addr_in <= SCR_OFS_ERR_LAST) begin
        next_s.rdata = des_err_data_in[2'(idx - SCR_OFS_ERR_FIRST[3:0])];
        // (RULE_04) clear on read
        if (!s.des[SCR_OFS_SPREAD[2:0]][SCR_AUTO_ERR_BIT]) begin
          next_s.err_clr[2'(idx - SCR_OFS_ERR_FIRST[3:0])] = 1'b1;
        end
      end
    end

    // 0,1 serializer start/end; 2,3 deserializer start/end
    // (RULE_05) (RULE_06) divided timeout timers
    for (int i = 0; i < SCR_TIMERS; i++) begin
      cfg   = (i < 2) ? s.ser[SCR_OFS_START_TO[3:0] + 4'(i)]
                      : s.des[SCR_OFS_START_TO[2:0] + 3'(i - 2)];
      div   = cfg[SCR_DIV_LSB +: 4];
      term  = cfg[3:0];
      limit = 16'((17'h1 << div) - 17'h1);
      if (timer_restart_in[i]) begin
        next_s.armed[i] = 1'b1;
        next_s.pre[i]   = 16'h0000;
        next_s.cnt[i]   = 4'h0;
      end else if (s.armed[i]) begin
        if (s.pre[i] == limit) begin
          next_s.pre[i] = 16'h0000;
          if (s.cnt[i] == term) begin
            next_s.armed[i]   = 1'b0;
            next_s.expired[i] = 1'b1;
          end else begin
            next_s.cnt[i] = s.cnt[i] + 4'h1;
          end
        end else begin
          next_s.pre[i] = s.pre[i] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // (RULE_01) (RULE_02) (RULE_03) power-up values
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s     <= '0;
      // (RULE_08) edge defaults, pll kept
      // (RULE_09) deserializer edge 0x20
      // (RULE_10) link addresses loaded
      // (RULE_11) end-frame bytes 0xFF
      // (RULE_12) peripheral port off
      // (RULE_13) slow uart rates
      // (RULE_14) come-back timeout off
      // (RULE_15) full pattern length
      // (RULE_17) zero emphasis
      // (RULE_18) widest glitch filter
      s.ser <= SCR_SER_RESET;
      s.des <= SCR_DES_RESET;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cc_rdata_out      = s.rdata;
  assign cc_rvalid_out     = s.rvalid;
  assign init_done_out     = s.init_done;
  assign ser_cfg_out       = s.ser;
  assign des_cfg_out       = s.des;
  assign des_err_clear_out = s.err_clr;
  assign timer_expired_out = s.expired;
  // (RULE_16) ten pin controls
  assign ser_pin_dir_out   = {s.ser[SCR_OFS_TEST_PINS[3:0]][SCR_HI_DIR_LSB +: 2],
                              s.ser[SCR_OFS_DIR_LOW[3:0]]};
  assign ser_pin_value_out = {s.ser[SCR_OFS_TEST_PINS[3:0]][1:0],
                              s.ser[SCR_OFS_VAL_LOW[3:0]]};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  logic init_rise;
  assign init_rise = ce_in && !s.init_done && s.init_cnt == SCR_INIT_WAIT;
  logic ser_wr;
  logic des_wr;
  assign ser_wr = ce_in && cc_wr_in && s.init_done && !cc_bank_in;
  assign des_wr = ce_in && cc_wr_in && s.init_done && cc_bank_in;

  a_format_reset: assert property ( // RULE_01
    init_rise |=> s.ser[0] == 8'hB5 && s.des[0] == 8'hB5)
    else $error("link format not at power-up value");

  a_ser_spread: assert property ( // RULE_02
    init_rise |=> s.ser[1] == 8'h1F)
    else $error("serializer spread not at power-up value");

  a_des_spread: assert property ( // RULE_03
    init_rise |=> s.des[1] == 8'h00)
    else $error("deserializer spread not at power-up value");

  a_err_clear: assert property ( // RULE_04
    ce_in && cc_rd_in && cc_bank_in && cc_addr_in == SCR_OFS_ERR_FIRST
    && !s.des[1][SCR_AUTO_ERR_BIT] |=> des_err_clear_out[0] && cc_rvalid_out)
    else $error("error count not cleared on read");

  a_timer_cause: assert property ( // RULE_05
    timer_expired_out[0] |-> !s.armed[0] && $past(s.armed[0]))
    else $error("start timer expired while idle");

  a_timeout_reset: assert property ( // RULE_06
    init_rise |=> s.ser[2] == 8'hA0 && s.ser[3] == 8'hA0
                  && s.des[2] == 8'hA0 && s.des[3] == 8'hA0)
    else $error("timeout registers not at power-up value");

  a_strap_edge: assert property ( // RULE_07
    init_rise |=> s.ser[4] == ($past(s.strap_sync) ? 8'h30 : 8'h28))
    else $error("edge register does not follow strap");

  a_power_pair: assert property ( // RULE_07
    $rose(s.init_done) |-> s.ser[4][SCR_POWER_DOWN_BIT] != s.ser[4][SCR_SER_ON_BIT])
    else $error("power down and enable not opposite at start");

  a_des_edge: assert property ( // RULE_09
    init_rise |=> s.des[4] == 8'h20)
    else $error("deserializer edge not at power-up value");

  a_link_addr: assert property ( // RULE_10
    init_rise |=> s.ser[5] == 8'hFA && s.des[5] == 8'hF8 && s.ser[7] == 8'hF8)
    else $error("link address not at power-up value");

  a_end_frame: assert property ( // RULE_11
    init_rise |=> s.ser[6] == 8'hFF && s.des[6] == 8'hFF)
    else $error("end frame byte not at power-up value");

  a_periph_reset: assert property ( // RULE_12
    init_rise |=> s.ser[8] == 8'h00 && s.des[7] == 8'h00)
    else $error("peripheral register not at power-up value");

  a_pins_reset: assert property ( // RULE_16
    init_rise |=> ser_pin_dir_out == 10'h000 && ser_pin_value_out == 10'h000)
    else $error("pins not inputs at start");

  a_emph_reserved: assert property ( // RULE_17
    s.ser[12][4:0] == 5'h00 && s.ser[1][4:0] == 5'h1F)
    else $error("reserved bits changed");

  a_filter_reset: assert property ( // RULE_18
    init_rise |=> s.ser[13] == 8'h00 && s.ser[12] == 8'hE0)
    else $error("filter or emphasis not at power-up value");

  a_write_mask: assert property ( // RULE_20
    ce_in && cc_wr_in && s.init_done && !cc_bank_in
    && cc_addr_in == SCR_OFS_EDGE |=>
    s.ser[4] == ($past(cc_wdata_in) & 8'hBD))
    else $error("edge write not masked");

  a_lock_status: assert property ( // RULE_20
    ce_in && s.init_done |=> s.ser[14] == {7'h00, $past(s.lock_sync)})
    else $error("lock status register wrong");

  a_read_answer: assert property ( // RULE_20
    ce_in && cc_rd_in |=> cc_rvalid_out)
    else $error("read not answered");

  a_read_quiet: assert property ( // RULE_20
    ce_in && !cc_rd_in |=> !cc_rvalid_out)
    else $error("read valid without a read");

  a_err_last: assert property ( // RULE_04
    ce_in && cc_rd_in && cc_bank_in && cc_addr_in == SCR_OFS_ERR_LAST
    && !s.des[1][SCR_AUTO_ERR_BIT] |=> des_err_clear_out == 4'h8)
    else $error("last error count not cleared on read");

  a_err_kept: assert property ( // RULE_04
    ce_in && s.des[1][SCR_AUTO_ERR_BIT] |=> des_err_clear_out == 4'h0)
    else $error("error count cleared with auto reset set");

  a_err_idle: assert property ( // RULE_04
    ce_in && !(cc_rd_in && cc_bank_in) |=> des_err_clear_out == 4'h0)
    else $error("error count cleared without a read");

  a_timer_pulse: assert property ( // RULE_05
    ce_in && timer_expired_out[0] |=> !timer_expired_out[0])
    else $error("start timer pulse too long");

  a_timer_ser_end: assert property ( // RULE_06
    timer_expired_out[1] |-> !s.armed[1] && $past(s.armed[1]))
    else $error("end timer expired while idle");

  a_timer_des_start: assert property ( // RULE_05
    timer_expired_out[2] |-> !s.armed[2] && $past(s.armed[2]))
    else $error("far start timer expired while idle");

  a_timer_des_end: assert property ( // RULE_06
    timer_expired_out[3] |-> !s.armed[3] && $past(s.armed[3]))
    else $error("far end timer expired while idle");

  a_init_hold: assert property ( // RULE_07
    s.init_done |=> s.init_done)
    else $error("strap load repeated");

  a_edge_reserved: assert property ( // RULE_08
    s.ser[4][6] == 1'b0 && s.ser[4][1] == 1'b0)
    else $error("edge register reserved bits changed");

  a_des_reserved: assert property ( // RULE_09
    s.des[1][4:0] == 5'h00 && s.des[4][4:1] == 4'h0)
    else $error("deserializer reserved bits changed");

  a_filter_reserved: assert property ( // RULE_18
    s.ser[13][7:2] == 6'h00)
    else $error("filter reserved bits changed");

  a_lock_reserved: assert property ( // RULE_20
    s.ser[14][7:1] == 7'h00)
    else $error("lock register reserved bits changed");

  a_pin_write: assert property ( // RULE_16
    ser_wr && cc_addr_in == SCR_OFS_DIR_LOW |=> ser_pin_dir_out[7:0] == $past(cc_wdata_in))
    else $error("pin direction write lost");

  a_spread_write: assert property ( // RULE_02
    ser_wr && cc_addr_in == SCR_OFS_SPREAD |=>
    s.ser[1] == {$past(cc_wdata_in[7:5]), 5'h1F})
    else $error("spread write not masked");

  a_emph_write: assert property ( // RULE_17
    ser_wr && cc_addr_in == SCR_OFS_EMPHASIS |=>
    s.ser[12] == {$past(cc_wdata_in[7:5]), 5'h00})
    else $error("emphasis write not masked");

  a_des_write: assert property ( // RULE_09
    des_wr && cc_addr_in == SCR_OFS_EDGE |=> s.des[4] == ($past(cc_wdata_in) & 8'hE1))
    else $error("deserializer edge write not masked");

  a_early_write: assert property ( // RULE_20
    ce_in && !s.init_done |=> s.des == $past(s.des) && s.ser[3:0] == $past(s.ser[3:0])
    && s.ser[13:5] == $past(s.ser[13:5]))
    else $error("register changed before strap load");

  a_state_frozen: assert property ( // RULE_20
    !ce_in |=> s == $past(s))
    else $error("state moved with clock enable low");

  c_strap_high: cover property (init_rise ##1 s.ser[4] == 8'h30);
  c_err_clear:  cover property (des_err_clear_out != 4'h0);
  c_timer_exp:  cover property (timer_expired_out[0]);
  c_ser_write:  cover property (ce_in && cc_wr_in && s.init_done && !cc_bank_in);
  c_des_write:  cover property (des_wr);

endmodule

// File: testbench/scr_control_unit.sv
`timescale 1ns/1ps
// stand-in for the control unit; drives the register port off the falling edge
module scr_control_unit (
  input  wire logic       clk_in,
  input  wire logic       init_done_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output logic            cc_bank_out,
  output logic            cc_wr_out,
  output logic            cc_rd_out,
  output logic [7:0]      cc_addr_out,
  output logic [7:0]      cc_wdata_out
);
  initial begin
    cc_bank_out = 1'b0;
    cc_wr_out = 1'b0;
    cc_rd_out = 1'b0;
    cc_addr_out = 8'h00;
    cc_wdata_out = 8'h00;
  end
  // idle bus shows inverted address and data leftovers; bank keeps its last value
  task automatic release_bus();
    cc_wr_out = 1'b0;
    cc_rd_out = 1'b0;
    cc_addr_out = ~cc_addr_out;
    cc_wdata_out = ~cc_wdata_out;
  endtask
  task automatic wr(input logic bank, input logic [7:0] addr, input logic [7:0] data);
    if (init_done_in !== 1'b1) begin
      $display("control unit write issued before the channel opened");
    end
    @(negedge clk_in);
    cc_bank_out = bank;
    cc_addr_out = addr;
    cc_wdata_out = data;
    cc_wr_out = 1'b1;
    @(negedge clk_in);
    release_bus();
  endtask
  task automatic rd(input logic bank, input logic [7:0] addr, output logic [7:0] data,
                    output logic valid);
    @(negedge clk_in);
    cc_bank_out = bank;
    cc_addr_out = addr;
    cc_rd_out = 1'b1;
    @(negedge clk_in);
    data = rdata_in;
    valid = rvalid_in;
    release_bus();
  endtask
endmodule

// File: testbench/scr_config_bank_bench.sv
`timescale 1ns/1ps
module scr_config_bank_bench;
  localparam logic [14:0][7:0] SER_EXP = {8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hF8, 8'hFF, 8'hFA, 8'h28, 8'hA0, 8'hA0, 8'h1F, 8'hB5};
  localparam logic [7:0][7:0]  DES_EXP = {8'h00, 8'hFF, 8'hF8, 8'h20, 8'hA0, 8'hA0, 8'h00,
    8'hB5};
  // bank, offset, written, read back
  localparam logic [31:0] WR_TAB [9] = '{32'h0001001F, 32'h000CFFE0, 32'h000DFF03,
    32'h0004FFBD, 32'h000EFF00, 32'h0101FFE0, 32'h0104FFE1, 32'h0108FF00, 32'h000FFF00};
  logic             clk_in = 1'b0;
  logic             rst_b_in;
  logic             ce_in;
  logic             remote_strap_in;
  logic             ser_locked_in;
  logic [3:0][7:0]  des_err_data_in;
  logic [3:0]       timer_restart_in;
  logic             cc_bank, cc_wr, cc_rd;
  logic [7:0]       cc_addr, cc_wdata, cc_rdata_out;
  logic             cc_rvalid_out, init_done_out;
  logic [14:0][7:0] ser_cfg_out;
  logic [7:0][7:0]  des_cfg_out;
  logic [9:0]       ser_pin_dir_out, ser_pin_value_out;
  logic [3:0]       des_err_clear_out, timer_expired_out;
  logic [7:0]       rdata;
  logic             rvalid;
  int               failures = 0;
  int               cmp_count = 0;

  always #50 clk_in = ~clk_in;

  scr_control_unit cu (.clk_in(clk_in), .init_done_in(init_done_out),
    .rvalid_in(cc_rvalid_out), .rdata_in(cc_rdata_out), .cc_bank_out(cc_bank),
    .cc_wr_out(cc_wr), .cc_rd_out(cc_rd), .cc_addr_out(cc_addr), .cc_wdata_out(cc_wdata));
  scr_config_bank dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .remote_strap_in(remote_strap_in), .ser_locked_in(ser_locked_in), .cc_bank_in(cc_bank),
    .cc_wr_in(cc_wr), .cc_rd_in(cc_rd), .cc_addr_in(cc_addr), .cc_wdata_in(cc_wdata),
    .des_err_data_in(des_err_data_in), .timer_restart_in(timer_restart_in),
    .cc_rdata_out(cc_rdata_out), .cc_rvalid_out(cc_rvalid_out),
    .init_done_out(init_done_out), .ser_cfg_out(ser_cfg_out), .des_cfg_out(des_cfg_out),
    .ser_pin_dir_out(ser_pin_dir_out), .ser_pin_value_out(ser_pin_value_out),
    .des_err_clear_out(des_err_clear_out), .timer_expired_out(timer_expired_out));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reset_dut(input logic strap);
    rst_b_in = 1'b0;
    remote_strap_in = strap;
    repeat (6) @(negedge clk_in);
    rst_b_in = 1'b1;
    for (int k = 0; k < 10 && init_done_out !== 1'b1; k++) begin
      @(negedge clk_in);
    end
    if (init_done_out !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask
  // restart edge is the one after the raising fall; pulse expected n edges later
  task automatic timer_run(input int i, input int n);
    int k;
    @(negedge clk_in);
    timer_restart_in = 4'h1 << i;
    @(negedge clk_in);
    timer_restart_in = 4'h0;
    for (k = 1; k <= n + 1 && timer_expired_out[i] !== 1'b1; k++) begin
      @(negedge clk_in);
    end
    check(k[15:0], n[15:0] + 16'h1);
    @(negedge clk_in);
    check(timer_expired_out[i], 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_strap_high();
    check(ser_cfg_out[4], 8'h30);
  endtask
  task automatic t_reset_values();
    for (int i = 0; i < 15; i++) begin
      cu.rd(1'b0, i[7:0], rdata, rvalid);
      check({rvalid, rdata}, {1'b1, SER_EXP[i]});
    end
    for (int i = 0; i < 8; i++) begin
      check(des_cfg_out[i], DES_EXP[i]);
    end
    check(ser_pin_dir_out, 10'h000);
    check(ser_pin_value_out, 10'h000);
    check(ser_cfg_out[4], 8'h28);
    check(ser_cfg_out[8], 8'h00);
  endtask
  task automatic t_reserved();
    foreach (WR_TAB[j]) begin
      cu.wr(WR_TAB[j][24], WR_TAB[j][23:16], WR_TAB[j][15:8]);
      cu.rd(WR_TAB[j][24], WR_TAB[j][23:16], rdata, rvalid);
      check({rvalid, rdata}, {1'b1, WR_TAB[j][7:0]});
    end
  endtask
  task automatic t_pins();
    cu.wr(1'b0, 8'h0A, 8'hA5);
    cu.wr(1'b0, 8'h0B, 8'h3C);
    cu.wr(1'b0, 8'h09, 8'hF6);
    check(ser_pin_dir_out, 10'h1A5);
    check(ser_pin_value_out, 10'h23C);
    check(ser_cfg_out[9], 8'hF6);
  endtask
  task automatic t_lock();
    ser_locked_in = 1'b1;
    repeat (3) @(negedge clk_in);
    cu.rd(1'b0, 8'h0E, rdata, rvalid);
    check(rdata, 8'h01);
  endtask
  task automatic t_hold();
    ce_in = 1'b0;
    cu.wr(1'b0, 8'h06, 8'h5A);
    ce_in = 1'b1;
    check(ser_cfg_out[6], 8'hFF);
  endtask
  task automatic t_err_clear();
    for (int a = 0; a < 2; a++) begin
      cu.wr(1'b1, 8'h01, a[0] ? 8'h20 : 8'h00);
      for (int k = 0; k < 4; k++) begin
        cu.rd(1'b1, 8'h0A + k[7:0], rdata, rvalid);
        check(rdata, des_err_data_in[k]);
        check(des_err_clear_out, a[0] ? 4'h0 : 4'h1 << k);
      end
    end
  endtask
  task automatic t_timers();
    timer_run(0, 1024);
    for (int i = 0; i < 4; i++) begin
      cu.wr(i[1], 8'h02 + {7'h0, i[0]}, 8'h12);
      // faster prescale, longer count: six edges
      timer_run(i, 6);
    end
  endtask

  initial begin
    ce_in = 1'b1;
    ser_locked_in = 1'b0;
    des_err_data_in = {8'h44, 8'h33, 8'h22, 8'h11};
    timer_restart_in = 4'h0;
    reset_dut(1'b1);
    t_strap_high();
    reset_dut(1'b0);
    t_reset_values();
    t_hold();
    t_timers();
    t_reserved();
    t_pins();
    t_lock();
    t_err_clear();
    end_sim();
  end
endmodule
